// ---- rtl/esos_edge_latch.sv ----
/*
  Activity event latch: catches each rising condition bit and holds it
  until the returned bits are cleared by a read.
  Assumes conditions are synchronous to core_clk_i.
*/
`timescale 1ns/1ns
`include "esos_map.svh"

module esos_edge_latch (
  input  wire logic        core_clk_i,  // Instrument clock
  input  wire logic        reset_n_i,   // Async reset, active low
  input  wire logic [15:0] cond_i,      // Current activity conditions
  input  wire logic [15:0] clr_i,       // Bits returned by a read
  output logic      [15:0] event_o      // Latched activity events
);

  logic [15:0] cond_prev_r;
  logic [15:0] event_r;
  logic [15:0] rise_w;
  logic [15:0] event_nxt;

  assign rise_w    = cond_i & ~cond_prev_r;
  // New edge wins over the clear of the same cycle
  assign event_nxt = (event_r & ~clr_i) | rise_w;
  assign event_o   = event_r;

  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      cond_prev_r <= `ESOS_OPEN_RESET;
      event_r     <= `ESOS_OPEN_RESET;
    end else begin
      cond_prev_r <= cond_i;
      event_r     <= event_nxt;
    end
  end

  a_edge_latches: assert property (@(posedge core_clk_i)
    disable iff (!reset_n_i) (|rise_w) |=> ((event_r & $past(rise_w))
    == $past(rise_w)))
    else $error("Rising activity not latched");

endmodule // esos_edge_latch

// ---- rtl/esos_map.svh ----
/*
  Constants for the event and operation status block: field positions,
  reset values and error code limits.
  Assumes inclusion by bare name from the design files.
*/
`ifndef ESOS_MAP_SVH
`define ESOS_MAP_SVH

// Event status latch bit positions
`define ESOS_EV_OPC        0
`define ESOS_EV_UNUSED     1
`define ESOS_EV_QUERY      2
`define ESOS_EV_DEVICE     3
`define ESOS_EV_EXEC       4
`define ESOS_EV_COMMAND    5
`define ESOS_EV_LOCAL      6
`define ESOS_EV_POWER      7

// Status byte bit positions
`define ESOS_SB_ERRQ       2
`define ESOS_SB_QUES       3
`define ESOS_SB_MAV        4
`define ESOS_SB_ESB        5
`define ESOS_SB_MSS        6
`define ESOS_SB_OPER       7

// Activity status bit positions
`define ESOS_OP_CAL        0
`define ESOS_OP_SWEEP      3
`define ESOS_OP_MEAS       4
`define ESOS_OP_TRIG       5
`define ESOS_OP_HCOPY      8
`define ESOS_OP_CAPTURE    9
`define ESOS_OP_RANGE      10
`define ESOS_OP_ZERO       15

// Reset values
`define ESOS_ESR_RESET     8'h80
`define ESOS_ESE_RESET     8'h00
`define ESOS_PPE_RESET     8'h00
`define ESOS_OPEN_RESET    16'h0000

// Error code limits, two's complement
`define ESOS_CODE_M399     16'hFE71
`define ESOS_CODE_M300     16'hFED4
`define ESOS_CODE_M200     16'hFF38
`define ESOS_CODE_M100     16'hFF9C
`define ESOS_CODE_P1       16'h0001
`define ESOS_CODE_PMAX     16'h7FFF

`endif

// ---- rtl/esos_pkg.sv ----
/*
  Types for the event and operation status block.
  Assumes esos_map.svh is on the include path.
*/
package esos_pkg;

  // Common commands and status queries handled by this block
  typedef enum logic [3:0] {
    ESOS_CMD_ESR_Q   = 4'h0,
    ESOS_CMD_ESE_W   = 4'h1,
    ESOS_CMD_ESE_Q   = 4'h2,
    ESOS_CMD_PRE_W   = 4'h3,
    ESOS_CMD_PRE_Q   = 4'h4,
    ESOS_CMD_IST_Q   = 4'h5,
    ESOS_CMD_STB_Q   = 4'h6,
    ESOS_CMD_OPC     = 4'h7,
    ESOS_CMD_OCOND_Q = 4'h8,
    ESOS_CMD_OEVEN_Q = 4'h9,
    ESOS_CMD_OENAB_W = 4'hA,
    ESOS_CMD_OENAB_Q = 4'hB
  } esos_cmd_t;

endpackage

// ---- rtl/esos_status.sv ----
/*
  Event status, parallel poll flag and activity status of the instrument.
  Holds the event status latch and mask, the poll enable mask and the
  activity status register, and answers the common status commands.
  Assumes a command parser delivers one decoded command per cycle on the
  command port, and that all inputs are synchronous to core_clk_i.
*/
`timescale 1ns/1ns
`include "esos_map.svh"

// Notes on behaviour
// - Flag is OR of status byte AND poll mask
// - Poll mask includes status byte bit six
// - Flag readable by poll and query; mask writable
// - Enabled rising event sets event summary bit
// - Operation complete set when prior commands finish
// - Query error on unrequested read or unfetched data
// - Device error sets bit three, queues code
// - Execution error sets bit four, queues code
// - Command error sets bit five, queues code
// - Local control sets bit six; power-up bit seven
// - Event bit one has no function
// - Calibration bit held during whole calibration
// - Sweep and measure bits equal, unused in applications
// - Trigger wait bit while armed
// - Hardcopy bit while printing
// - Capture finish bit only in acquisition mode
// - Range completed bit when stop-after-range enabled
// - Bit fifteen zero; unused bits carry nothing
// - Activity register offers condition and event views
// - Summary from event and mask into higher register
// - Event summary bit is status byte bit five
// - Status byte bit seven summarises activity events
module esos_status (
  input  wire logic                  core_clk_i,        // Instrument clock
  input  wire logic                  reset_n_i,         // Async reset, low
  input  wire logic                  cmd_valid_i,       // Command strobe
  input  wire esos_pkg::esos_cmd_t   cmd_code_i,        // Command code
  input  wire logic [15:0]           cmd_data_i,        // Write argument
  input  wire logic                  other_cmd_i,       // Other new command
  input  wire logic                  talk_req_i,        // Controller reads
  input  wire logic                  msg_pending_i,     // Other data queued
  input  wire logic                  all_done_i,        // Prior cmds done
  input  wire logic                  dev_err_i,         // Device error
  input  wire logic                  exec_err_i,        // Execution error
  input  wire logic                  cmd_err_i,         // Command error
  input  wire logic [15:0]           err_code_i,        // Parser error code
  input  wire logic                  local_ctrl_i,      // Went to local
  input  wire logic                  err_queue_nempty_i, // Error queue used
  input  wire logic                  ques_summary_i,    // Questionable sum
  input  wire logic                  mss_i,             // Service summary
  input  wire logic                  calibration_active_i, // Calibration_active
  input  wire logic                  sweep_active_i,    // Base sweep running
  input  wire logic                  measurement_active_i, // Base measurement_active
  input  wire logic                  app_mode_i,        // Application active
  input  wire logic                  trig_wait_i,       // Armed for trigger
  input  wire logic                  hardcopy_i,        // Printing hardcopy
  input  wire logic                  multi_standard_acquisition_mode_i, // Mode
  input  wire logic                  capture_done_i,    // Capture finished ok
  input  wire logic                  stop_after_range_i, // Option enabled
  input  wire logic                  range_done_i,      // Range finished
  output logic                       resp_valid_o,      // Answer waiting
  output logic [15:0]                resp_data_o,       // Answer value
  output logic [7:0]                 status_byte_o,     // Status byte
  output logic                       individual_status_flag_o, // Poll flag
  output logic                       err_push_o,        // Queue error pulse
  output logic [15:0]                err_code_o         // Code to queue
);

  function automatic logic in_span(input logic [15:0] c,
                                   input logic [15:0] lo,
                                   input logic [15:0] hi);
    in_span = ($signed(c) >= $signed(lo)) && ($signed(c) <= $signed(hi));
  endfunction

  // Registers
  logic [7:0]  event_status_latch_r;
  logic [7:0]  event_status_mask_r;
  logic [7:0]  poll_enable_mask_r;
  logic [15:0] oper_enable_r;
  logic [15:0] oper_cond_r;
  logic        opc_armed_r;
  logic        resp_valid_r;
  logic [15:0] resp_data_r;
  logic [7:0]  status_byte_r;
  logic        ist_r;
  logic        err_push_r;
  logic [15:0] err_code_r;

  // Next values and decoded strobes
  logic [7:0]  esr_nxt;
  logic [7:0]  esr_set_w;
  logic [7:0]  esr_clr_w;
  logic [15:0] oper_cond_nxt;
  logic [15:0] oper_event_w;
  logic [15:0] oper_clr_w;
  logic [7:0]  stb_w;
  logic        ist_w;
  logic        esb_w;
  logic        oper_sum_w;
  logic        opc_hit_w;
  logic        qerr_w;
  logic        is_query_w;
  logic [15:0] query_val_w;
  logic        resp_valid_nxt;
  logic        err_any_w;
  logic [15:0] err_code_nxt;
  logic        base_busy_w;

  wire cmd_esr_q   = cmd_valid_i && cmd_code_i == esos_pkg::ESOS_CMD_ESR_Q;
  wire cmd_ese_w   = cmd_valid_i && cmd_code_i == esos_pkg::ESOS_CMD_ESE_W;
  wire cmd_ese_q   = cmd_valid_i && cmd_code_i == esos_pkg::ESOS_CMD_ESE_Q;
  wire cmd_pre_w   = cmd_valid_i && cmd_code_i == esos_pkg::ESOS_CMD_PRE_W;
  wire cmd_pre_q   = cmd_valid_i && cmd_code_i == esos_pkg::ESOS_CMD_PRE_Q;
  wire cmd_ist_q   = cmd_valid_i && cmd_code_i == esos_pkg::ESOS_CMD_IST_Q;
  wire cmd_stb_q   = cmd_valid_i && cmd_code_i == esos_pkg::ESOS_CMD_STB_Q;
  wire cmd_opc     = cmd_valid_i && cmd_code_i == esos_pkg::ESOS_CMD_OPC;
  wire cmd_ocond_q = cmd_valid_i && cmd_code_i == esos_pkg::ESOS_CMD_OCOND_Q;
  wire cmd_oeven_q = cmd_valid_i && cmd_code_i == esos_pkg::ESOS_CMD_OEVEN_Q;
  wire cmd_oenab_w = cmd_valid_i && cmd_code_i == esos_pkg::ESOS_CMD_OENAB_W;
  wire cmd_oenab_q = cmd_valid_i && cmd_code_i == esos_pkg::ESOS_CMD_OENAB_Q;

  // Activity conditions; unused bits and bit 15 stay zero
  assign base_busy_w = !app_mode_i &&
                       (sweep_active_i || measurement_active_i);
  always_comb begin
    oper_cond_nxt                   = 16'h0000;
    oper_cond_nxt[`ESOS_OP_CAL]     = calibration_active_i;
    oper_cond_nxt[`ESOS_OP_SWEEP]   = base_busy_w;
    oper_cond_nxt[`ESOS_OP_MEAS]    = base_busy_w;
    oper_cond_nxt[`ESOS_OP_TRIG]    = trig_wait_i;
    oper_cond_nxt[`ESOS_OP_HCOPY]   = hardcopy_i;
    oper_cond_nxt[`ESOS_OP_CAPTURE] = multi_standard_acquisition_mode_i &&
                                      capture_done_i;
    oper_cond_nxt[`ESOS_OP_RANGE]   = stop_after_range_i &&
                                      range_done_i;
  end

  // Event view of the activity register
  assign oper_clr_w = cmd_oeven_q ? oper_event_w : 16'h0000;
  esos_edge_latch u_oper_events (
    .core_clk_i (core_clk_i),
    .reset_n_i  (reset_n_i),
    .cond_i     (oper_cond_r),
    .clr_i      (oper_clr_w),
    .event_o    (oper_event_w)
  );

  // Operation complete fires as soon as earlier commands are done
  assign opc_hit_w = (opc_armed_r || cmd_opc) && all_done_i;

  // Unrequested read, or new command while an answer is unfetched
  assign qerr_w = (talk_req_i && !resp_valid_r && !msg_pending_i) ||
                  ((cmd_valid_i || other_cmd_i) &&
                   (resp_valid_r || msg_pending_i));

  always_comb begin
    esr_set_w                   = 8'h00;
    esr_set_w[`ESOS_EV_OPC]     = opc_hit_w;
    esr_set_w[`ESOS_EV_QUERY]   = qerr_w;
    esr_set_w[`ESOS_EV_DEVICE]  = dev_err_i;
    esr_set_w[`ESOS_EV_EXEC]    = exec_err_i;
    esr_set_w[`ESOS_EV_COMMAND] = cmd_err_i;
    esr_set_w[`ESOS_EV_LOCAL]   = local_ctrl_i;
  end
  assign esr_clr_w = cmd_esr_q ? event_status_latch_r : 8'h00;
  assign esr_nxt   = (event_status_latch_r & ~esr_clr_w) | esr_set_w;

  // Summary bits feed the status byte
  assign esb_w      = |(event_status_latch_r & event_status_mask_r);
  assign oper_sum_w = |(oper_event_w & oper_enable_r);
  always_comb begin
    stb_w                 = 8'h00;
    stb_w[`ESOS_SB_ERRQ]  = err_queue_nempty_i;
    stb_w[`ESOS_SB_QUES]  = ques_summary_i;
    stb_w[`ESOS_SB_MAV]   = resp_valid_r || msg_pending_i;
    stb_w[`ESOS_SB_ESB]   = esb_w;
    stb_w[`ESOS_SB_MSS]   = mss_i;
    stb_w[`ESOS_SB_OPER]  = oper_sum_w;
  end
  // Bit 6 is not masked out here
  assign ist_w = |(status_byte_r & poll_enable_mask_r);

  // Query answers
  assign is_query_w  = cmd_esr_q || cmd_ese_q || cmd_pre_q || cmd_ist_q ||
                       cmd_stb_q || cmd_ocond_q || cmd_oeven_q ||
                       cmd_oenab_q;
  assign query_val_w =
    cmd_esr_q   ? {8'h00, event_status_latch_r} :
    cmd_ese_q   ? {8'h00, event_status_mask_r}  :
    cmd_pre_q   ? {8'h00, poll_enable_mask_r}   :
    cmd_ist_q   ? {15'h0000, ist_r}             :
    cmd_stb_q   ? {8'h00, status_byte_r}        :
    cmd_ocond_q ? oper_cond_r                   :
    cmd_oeven_q ? oper_event_w                  :
    cmd_oenab_q ? oper_enable_r                 : 16'h0000;
  assign resp_valid_nxt = is_query_w ? 1'b1 :
                          (talk_req_i ? 1'b0 : resp_valid_r);

  // Error queue entry; command error has priority, out-of-class codes
  // are replaced by the class default
  assign err_any_w    = dev_err_i || exec_err_i || cmd_err_i;
  assign err_code_nxt =
    cmd_err_i  ? (in_span(err_code_i, `ESOS_CODE_M200, `ESOS_CODE_M100) ?
                  err_code_i : `ESOS_CODE_M100) :
    exec_err_i ? (in_span(err_code_i, `ESOS_CODE_M300, `ESOS_CODE_M200) ?
                  err_code_i : `ESOS_CODE_M200) :
    (in_span(err_code_i, `ESOS_CODE_M399, `ESOS_CODE_M300) ||
     in_span(err_code_i, `ESOS_CODE_P1, `ESOS_CODE_PMAX)) ?
      err_code_i : `ESOS_CODE_M300;

  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      event_status_latch_r <= `ESOS_ESR_RESET;
      event_status_mask_r  <= `ESOS_ESE_RESET;
      poll_enable_mask_r   <= `ESOS_PPE_RESET;
      oper_enable_r        <= `ESOS_OPEN_RESET;
      oper_cond_r          <= `ESOS_OPEN_RESET;
      opc_armed_r          <= 1'b0;
    end else begin
      event_status_latch_r <= esr_nxt;
      if (cmd_ese_w) begin
        event_status_mask_r <= cmd_data_i[7:0];
      end
      if (cmd_pre_w) begin
        poll_enable_mask_r <= cmd_data_i[7:0];
      end
      if (cmd_oenab_w) begin
        oper_enable_r <= cmd_data_i;
      end
      oper_cond_r <= oper_cond_nxt;
      opc_armed_r <= (opc_armed_r || cmd_opc) && !all_done_i;
    end
  end

  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      resp_valid_r  <= 1'b0;
      resp_data_r   <= 16'h0000;
      status_byte_r <= 8'h00;
      ist_r         <= 1'b0;
      err_push_r    <= 1'b0;
      err_code_r    <= 16'h0000;
    end else begin
      resp_valid_r  <= resp_valid_nxt;
      if (is_query_w) begin
        resp_data_r <= query_val_w;
      end
      status_byte_r <= stb_w;
      ist_r         <= ist_w;
      err_push_r    <= err_any_w;
      if (err_any_w) begin
        err_code_r <= err_code_nxt;
      end
    end
  end

  assign resp_valid_o             = resp_valid_r;
  assign resp_data_o              = resp_data_r;
  assign status_byte_o            = status_byte_r;
  assign individual_status_flag_o = ist_r;
  assign err_push_o               = err_push_r;
  assign err_code_o               = err_code_r;

  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (!reset_n_i);

  a_ist_or_mask: assert property (
    ##1 ist_r == |($past(status_byte_r) & $past(poll_enable_mask_r)))
    else $error("Poll flag differs from masked status byte");

  a_ist_bit_six: assert property (
    (status_byte_r[`ESOS_SB_MSS] && poll_enable_mask_r[`ESOS_SB_MSS])
    |=> ist_r)
    else $error("Bit six ignored in poll flag");

  a_esb_summary: assert property (
    (|(event_status_latch_r & event_status_mask_r))
    |=> status_byte_r[`ESOS_SB_ESB])
    else $error("Event summary bit missing");

  a_opc_complete: assert property (
    ((opc_armed_r || cmd_opc) && all_done_i)
    |=> event_status_latch_r[`ESOS_EV_OPC])
    else $error("Operation complete not set");

  a_query_error: assert property (
    (talk_req_i && !resp_valid_r && !msg_pending_i)
    |=> event_status_latch_r[`ESOS_EV_QUERY])
    else $error("Query error not flagged");

  a_cmd_err_code: assert property (
    cmd_err_i |=> err_push_o && $signed(err_code_o) >= -200 &&
    $signed(err_code_o) <= -100)
    else $error("Command error code out of class");

  a_bit_one_idle: assert property (
    !event_status_latch_r[`ESOS_EV_UNUSED])
    else $error("Unused event bit set");

  a_cal_held: assert property (
    calibration_active_i [*2] |=> oper_cond_r[`ESOS_OP_CAL] [*1])
    else $error("Calibration bit not held");

  a_sweep_twin: assert property (
    oper_cond_r[`ESOS_OP_SWEEP] == oper_cond_r[`ESOS_OP_MEAS] &&
    !($past(app_mode_i) && oper_cond_r[`ESOS_OP_SWEEP]))
    else $error("Sweep and measure bits disagree");

  a_bit_fifteen: assert property (
    !oper_cond_r[`ESOS_OP_ZERO] && !oper_event_w[`ESOS_OP_ZERO])
    else $error("Activity bit fifteen set");

  a_oper_summary: assert property (
    (|(oper_event_w & oper_enable_r)) |=> status_byte_r[`ESOS_SB_OPER])
    else $error("Activity summary missing");

  a_esr_read_clr: assert property (
    (cmd_esr_q && !(|esr_set_w)) |=> event_status_latch_r == 8'h00)
    else $error("Event status not cleared by read");

  c_opc_set: cover property (cmd_opc ##[1:20] opc_hit_w);
  c_esr_read: cover property (cmd_esr_q ##1 resp_valid_r ##1 talk_req_i);
  c_ist_high: cover property ($rose(individual_status_flag_o));
  c_oper_event: cover property ($rose(oper_event_w[`ESOS_OP_RANGE]));

endmodule // esos_status

// ---- testbench/esos_ctrl_model.sv ----
/* Remote controller model: sends decoded commands, fetches answers.
   Assumes the status block samples on the rising edge of core_clk_i. */
`timescale 1ns/1ns
module esos_ctrl_model (
  input  wire logic          core_clk_i,   // Instrument clock
  input  wire logic          resp_valid_i, // Answer waiting
  input  wire logic [15:0]   resp_data_i,  // Answer value
  output logic               cmd_valid_o,  // Command strobe
  output esos_pkg::esos_cmd_t cmd_code_o,  // Command code
  output logic [15:0]        cmd_data_o,   // Write argument
  output logic               other_cmd_o,  // Other command
  output logic               talk_req_o    // Fetch request
);
  initial begin
    cmd_valid_o = 1'b0;
    cmd_code_o  = esos_pkg::ESOS_CMD_ESR_Q;
    cmd_data_o  = 16'h0000;
    other_cmd_o = 1'b0;
    talk_req_o  = 1'b0;
  end
  task automatic send(input esos_pkg::esos_cmd_t code,
                      input logic [15:0] data);
    @(posedge core_clk_i);
    #1;
    cmd_valid_o = 1'b1;
    cmd_code_o  = code;
    cmd_data_o  = data;
    @(posedge core_clk_i);
    #1;
    cmd_valid_o = 1'b0;
    // Released argument must not look stable
    cmd_data_o  = ~data;
  endtask
  task automatic talk();
    @(posedge core_clk_i);
    #1;
    talk_req_o = 1'b1;
    @(posedge core_clk_i);
    #1;
    talk_req_o = 1'b0;
  endtask
  task automatic other();
    @(posedge core_clk_i);
    #1;
    other_cmd_o = 1'b1;
    @(posedge core_clk_i);
    #1;
    other_cmd_o = 1'b0;
  endtask
  task automatic query(input esos_pkg::esos_cmd_t code,
                       output logic [15:0] data, output logic ok);
    send(code, 16'h0000);
    ok = 1'b0;
    for (int i = 0; i < 4 && !ok; i++) begin
      if (resp_valid_i === 1'b1)
        ok = 1'b1;
      else
        @(posedge core_clk_i) #1;
    end
    data = resp_data_i;
    talk();
  endtask
endmodule // esos_ctrl_model

// ---- testbench/test_event_status_and_operation_status.sv ----
/* Self-checking bench for esos_status with a controller model.
   Assumes the rtl package, header and design are compiled first. */
`timescale 1ns/1ns
module test_event_status_and_operation_status;
  logic                core_clk_i, reset_n_i, msg_pending_i, all_done_i;
  logic                cmd_valid, other_cmd, talk_req, resp_valid, individual_status_flag, push;
  esos_pkg::esos_cmd_t cmd_code;
  logic [15:0]         cmd_data, err_code_i, resp_data, err_code, cond;
  logic [9:0]          act;
  logic [3:0]          evp;
  logic [2:0]          st;
  logic [7:0]          stb, mask, pre, sbx;
  int                  err_total, cmp_count, seed, k, n, c, b;
  logic [15:0]         code_q[$];

  esos_ctrl_model ctrl_u (.core_clk_i, .resp_valid_i(resp_valid),
    .resp_data_i(resp_data), .cmd_valid_o(cmd_valid), .cmd_code_o(cmd_code),
    .cmd_data_o(cmd_data), .other_cmd_o(other_cmd), .talk_req_o(talk_req));

  esos_status dut_u (.core_clk_i, .reset_n_i, .cmd_valid_i(cmd_valid),
    .cmd_code_i(cmd_code), .cmd_data_i(cmd_data), .other_cmd_i(other_cmd),
    .talk_req_i(talk_req), .msg_pending_i, .all_done_i, .dev_err_i(evp[0]),
    .exec_err_i(evp[1]), .cmd_err_i(evp[2]), .err_code_i,
    .local_ctrl_i(evp[3]), .err_queue_nempty_i(st[0]),
    .ques_summary_i(st[1]), .mss_i(st[2]), .calibration_active_i(act[0]),
    .sweep_active_i(act[1]), .measurement_active_i(act[2]),
    .app_mode_i(act[3]), .trig_wait_i(act[4]), .hardcopy_i(act[5]),
    .multi_standard_acquisition_mode_i(act[6]), .capture_done_i(act[7]),
    .stop_after_range_i(act[8]), .range_done_i(act[9]),
    .resp_valid_o(resp_valid), .resp_data_o(resp_data),
    .status_byte_o(stb), .individual_status_flag_o(individual_status_flag),
    .err_push_o(push), .err_code_o(err_code));

  initial begin
    core_clk_i = 1'b0;
    forever #20 core_clk_i = ~core_clk_i;
  end

  // Error queue model: every push must carry the oldest expected code
  always @(negedge core_clk_i) begin
    if (reset_n_i === 1'b1 && push === 1'b1) begin
      if (code_q.size() == 0) begin
        err_total++;
        $display("mismatch err_q expected none seen %h", err_code);
      end else begin
        check("err_q", code_q.pop_front(), err_code);
      end
    end
  end

  task automatic tick(input int cnt);
    repeat (cnt) @(posedge core_clk_i);
    #1;
  endtask
  task automatic results();
    $display("comparisons %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task automatic check(input string nm, input logic [15:0] exp,
                       input logic [15:0] got);
    cmp_count++;
    if (got !== exp) begin
      err_total++;
      $display("mismatch %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic qchk(input esos_pkg::esos_cmd_t code,
                      input logic [15:0] exp, input string nm);
    logic [15:0] d;
    logic        ok;
    ctrl_u.query(code, d, ok);
    if (!ok) begin
      err_total++;
      $display("mismatch %s expected answer seen none", nm);
      results();
    end else begin
      check(nm, exp, d);
    end
  endtask

  initial begin
    seed = 32'hFCCFD394;
    reset_n_i = 1'b0;
    msg_pending_i = 1'b0;
    all_done_i = 1'b1;
    err_code_i = 16'h0000;
    act = 10'h000;
    evp = 4'h0;
    st = 3'h0;
    err_total = 0;
    cmp_count = 0;
    tick(12);
    reset_n_i = 1'b1;
    qchk(esos_pkg::ESOS_CMD_ESR_Q, 16'h0080, "power_on");
    qchk(esos_pkg::ESOS_CMD_ESR_Q, 16'h0000, "esr_cleared");
    qchk(esos_pkg::ESOS_CMD_ESE_Q, 16'h0000, "ese_reset");
    qchk(esos_pkg::ESOS_CMD_PRE_Q, 16'h0000, "pre_reset");
    $display("test reset done");
    mask = 8'($random(seed)) | 8'h20;
    ctrl_u.send(esos_pkg::ESOS_CMD_ESE_W, {8'h00, mask});
    qchk(esos_pkg::ESOS_CMD_ESE_Q, {8'h00, mask}, "ese_back");
    // Classes: device, execution, command, local, command out of range
    for (k = 0; k < 5; k++) begin
      n = (k == 4) ? 2 : k;
      b = (n == 3) ? 6 : n + 3;
      c = (k == 4) ? 5 : (k - 2) * 100 - 150 + $random(seed) % 40;
      tick(1);
      err_code_i = c[15:0];
      if (n < 3)
        code_q.push_back((k == 4) ? 16'hFF9C : c[15:0]);
      evp[n] = 1'b1;
      tick(1);
      evp = 4'h0;
      if (n < 3) begin
        check("err_push", 16'h0001, {15'h0, push});
        check("err_code", (k == 4) ? 16'hFF9C : c[15:0], err_code);
      end
      tick(1);
      check("esb", {15'h0, mask[b]}, {15'h0, stb[5]});
      qchk(esos_pkg::ESOS_CMD_ESR_Q, 16'h0001 << b, "esr");
    end
    $display("test events done");
    ctrl_u.talk();
    qchk(esos_pkg::ESOS_CMD_ESR_Q, 16'h0004, "talk_idle");
    ctrl_u.send(esos_pkg::ESOS_CMD_ESE_Q, 16'h0000);
    ctrl_u.other();
    ctrl_u.talk();
    qchk(esos_pkg::ESOS_CMD_ESR_Q, 16'h0004, "unfetched");
    msg_pending_i = 1'b1;
    ctrl_u.other();
    msg_pending_i = 1'b0;
    qchk(esos_pkg::ESOS_CMD_ESR_Q, 16'h0004, "pending_cmd");
    all_done_i = 1'b0;
    ctrl_u.send(esos_pkg::ESOS_CMD_OPC, 16'h0000);
    tick(3);
    qchk(esos_pkg::ESOS_CMD_ESR_Q, 16'h0000, "opc_wait");
    all_done_i = 1'b1;
    tick(2);
    qchk(esos_pkg::ESOS_CMD_ESR_Q, 16'h0001, "opc_done");
    $display("test query and opc done");
    for (k = 0; k < 8; k++) begin
      pre = (k == 0) ? 8'h40 : 8'($random(seed));
      st = (k == 0) ? 3'h4 : 3'($random(seed));
      ctrl_u.send(esos_pkg::ESOS_CMD_PRE_W, {8'h00, pre});
      tick(3);
      sbx = {1'b0, st[2], 2'b00, st[1], st[0], 2'b00};
      check("stb", {8'h00, sbx}, {8'h00, stb});
      check("ist", {15'h0, |(sbx & pre)}, {15'h0, individual_status_flag});
      qchk(esos_pkg::ESOS_CMD_IST_Q, {15'h0, |(sbx & pre)}, "ist_q");
      qchk(esos_pkg::ESOS_CMD_STB_Q, {8'h00, sbx}, "stb_q");
      qchk(esos_pkg::ESOS_CMD_PRE_Q, {8'h00, pre}, "pre_back");
    end
    st = 3'h0;
    $display("test poll flag done");
    ctrl_u.send(esos_pkg::ESOS_CMD_OENAB_W, 16'hFFFF);
    qchk(esos_pkg::ESOS_CMD_OENAB_Q, 16'hFFFF, "oen_back");
    for (k = 0; k < 8; k++) begin
      act = 10'($random(seed));
      tick(4);
      cond = 16'h0000;
      cond[0] = act[0];
      cond[3] = (act[1] | act[2]) & ~act[3];
      cond[4] = cond[3];
      cond[5] = act[4];
      cond[8] = act[5];
      cond[9] = act[6] & act[7];
      cond[10] = act[8] & act[9];
      check("op_sum", {15'h0, |cond}, {15'h0, stb[7]});
      qchk(esos_pkg::ESOS_CMD_OCOND_Q, cond, "op_cond");
      qchk(esos_pkg::ESOS_CMD_OEVEN_Q, cond, "op_ev");
      act = 10'h000;
      tick(4);
      qchk(esos_pkg::ESOS_CMD_OEVEN_Q, 16'h0000, "op_clr");
      check("op_sum", 16'h0000, {15'h0, stb[7]});
    end
    $display("test activity done");
    check("err_q_left", 16'h0000, 16'(code_q.size()));
    results();
  end
endmodule // test_event_status_and_operation_status
